// ### design/egs_step_seq.sv
`timescale 1ns/1ps
`include "egs_regs.svh"
// Behaviour
// - generator is commanded over LAN or second GPIB port, per configured path.
// - TTL handshake only with GPIB path and capable generator; else per-point programming over the configured path.
// - non-TTL: program each point, wait completion, then enable capture.
// - TTL: load whole frequency list into generator before first TTL sweep and again after any list change not made while a list download is in progress.
// - TTL: pulse step-request line to advance generator to next list entry.
// - TTL: capture stays disabled until settling-done indication arrives.
// - no generator, bad address or not ready raises GPIB or TCP/IP error.
module egs_step_seq #(
  parameter int FREQ_W = `EGS_FREQ_W,
  parameter int DEPTH = `EGS_PTS_DEPTH,
  parameter int AW = $clog2(DEPTH),
  parameter int ACK_TIMEOUT = `EGS_ACK_TIMEOUT_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic gen_selected,
  input wire logic path_sel,
  input wire logic gen_ttl_capable,
  input wire logic addr_valid,
  input wire logic gen_ready,
  input wire logic pt_wr_en,
  input wire logic [AW-1:0] pt_wr_addr,
  input wire logic [FREQ_W-1:0] pt_wr_data,
  input wire logic [AW-1:0] last_index,
  input wire logic sweep_start,
  input wire logic list_invalidate,
  input wire logic cmd_ready,
  input wire logic cmd_done,
  input wire logic capture_done,
  input wire logic settle_pin,
  output logic cmd_valid,
  output logic cmd_load,
  output logic cmd_path,
  output logic [AW-1:0] cmd_index,
  output logic [FREQ_W-1:0] cmd_freq,
  output logic trig_pin,
  output logic capture_en,
  output logic [AW-1:0] point_index,
  output logic sweep_busy,
  output logic sweep_end,
  output egs_pkg::egs_err_t err_code,
  output logic err_pulse
);
  import egs_pkg::*;

  localparam int TRIG_CYC = `EGS_TRIG_PULSE_CYC;

  // ==========================================
  // pin synchroniser
  logic settle_s1;
  logic settle_s2;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      settle_s1 <= 1'b0;
      settle_s2 <= 1'b0;
    end else if (ce) begin
      settle_s1 <= settle_pin;
      settle_s2 <= settle_s1;
    end
  end

  // ==========================================
  // frequency list
  logic [AW-1:0] rd_addr;
  logic [FREQ_W-1:0] rd_data;
  egs_point_mem #(.WIDTH(FREQ_W), .DEPTH(DEPTH), .AW(AW)) u_mem (
    .clk(clk),
    .ce(ce),
    .wr_en(pt_wr_en),
    .wr_addr(pt_wr_addr),
    .wr_data(pt_wr_data),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );

  // ==========================================
  // sequencer
  egs_state_t state, next_state;
  logic [AW-1:0] idx, next_idx;
  logic [31:0] cnt, next_cnt;
  logic loaded, next_loaded;
  logic ttl_mode, next_ttl_mode;
  logic next_cmd_valid, next_cmd_load, next_cmd_path;
  logic [AW-1:0] next_cmd_index;
  logic [FREQ_W-1:0] next_cmd_freq;
  logic next_trig, next_capture_en, next_busy, next_end, next_err_pulse;
  egs_err_t next_err;

  always_comb begin
    next_state = state;
    next_idx = idx;
    next_cnt = cnt;
    next_loaded = loaded;
    next_ttl_mode = ttl_mode;
    next_cmd_valid = cmd_valid;
    next_cmd_load = cmd_load;
    next_cmd_path = cmd_path;
    next_cmd_index = cmd_index;
    next_cmd_freq = cmd_freq;
    next_trig = 1'b0;
    next_capture_en = 1'b0;
    next_busy = sweep_busy;
    next_end = 1'b0;
    next_err = err_code;
    next_err_pulse = 1'b0;
    rd_addr = idx;
    // a changed list forces a fresh download before the next TTL sweep, unless it arrives during a download, whose completion sets loaded again
    if (list_invalidate || pt_wr_en) begin
      next_loaded = 1'b0;
    end
    case (state)
      EGS_IDLE: begin
        if (sweep_start) begin
          next_state = EGS_CHECK;
          next_busy = 1'b1;
          next_err = EGS_ERR_NONE;
          next_cmd_path = path_sel;
          next_ttl_mode = (path_sel == `EGS_PATH_GPIB) && gen_ttl_capable;
        end
      end
      EGS_CHECK: begin
        next_idx = '0;
        next_cnt = '0;
        if (!gen_selected || !addr_valid || !gen_ready) begin
          next_err = (cmd_path == `EGS_PATH_GPIB) ? EGS_ERR_GPIB : EGS_ERR_TCPIP;
          next_err_pulse = 1'b1;
          next_busy = 1'b0;
          next_state = EGS_IDLE;
        end else if (ttl_mode && !loaded) begin
          next_state = EGS_LOAD_RD;
        end else if (ttl_mode) begin
          next_state = EGS_TRIG;
        end else begin
          next_state = EGS_SET_RD;
        end
      end
      EGS_LOAD_RD, EGS_SET_RD: begin
        next_state = (state == EGS_LOAD_RD) ? EGS_LOAD_SEND : EGS_SET_SEND;
      end
      EGS_LOAD_SEND, EGS_SET_SEND: begin
        next_cmd_valid = 1'b1;
        next_cmd_load = (state == EGS_LOAD_SEND);
        next_cmd_index = idx;
        next_cmd_freq = rd_data;
        next_cnt = '0;
        next_state = (state == EGS_LOAD_SEND) ? EGS_LOAD_WAIT : EGS_SET_WAIT;
      end
      EGS_LOAD_WAIT, EGS_SET_WAIT: begin
        if (cmd_valid && cmd_ready) begin
          next_cmd_valid = 1'b0;
        end
        next_cnt = cnt + 32'h1;
        if (!cmd_valid && cmd_done) begin
          next_cnt = '0;
          if (state == EGS_SET_WAIT) begin
            next_state = EGS_CAPTURE;
          end else if (idx == last_index) begin
            next_loaded = 1'b1;
            next_idx = '0;
            next_state = EGS_TRIG;
          end else begin
            next_idx = idx + 1'b1;
            next_state = EGS_LOAD_RD;
          end
        end else if (cnt >= ACK_TIMEOUT - 1) begin
          // generator silent: treated as not ready
          next_cmd_valid = 1'b0;
          next_err = (cmd_path == `EGS_PATH_GPIB) ? EGS_ERR_GPIB : EGS_ERR_TCPIP;
          next_err_pulse = 1'b1;
          next_busy = 1'b0;
          next_state = EGS_IDLE;
        end
      end
      EGS_TRIG: begin
        next_trig = 1'b1;
        next_cnt = cnt + 32'h1;
        // pin rises one cycle after entry, so compare against the full width
        if (cnt >= TRIG_CYC) begin
          next_trig = 1'b0;
          next_cnt = '0;
          next_state = EGS_SETTLE;
        end
      end
      EGS_SETTLE: begin
        next_cnt = cnt + 32'h1;
        if (settle_s2) begin
          next_cnt = '0;
          next_state = EGS_CAPTURE;
        end else if (cnt >= ACK_TIMEOUT - 1) begin
          next_err = EGS_ERR_GPIB;
          next_err_pulse = 1'b1;
          next_busy = 1'b0;
          next_state = EGS_IDLE;
        end
      end
      EGS_CAPTURE: begin
        next_capture_en = 1'b1;
        if (capture_done) begin
          next_capture_en = 1'b0;
          if (idx == last_index) begin
            next_state = EGS_DONE;
          end else begin
            next_idx = idx + 1'b1;
            next_state = ttl_mode ? EGS_TRIG : EGS_SET_RD;
          end
        end
      end
      EGS_DONE: begin
        next_busy = 1'b0;
        next_end = 1'b1;
        next_state = EGS_IDLE;
      end
      default: begin
        next_state = EGS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= EGS_IDLE;
      idx <= '0;
      cnt <= '0;
      loaded <= 1'b0;
      ttl_mode <= 1'b0;
      cmd_valid <= 1'b0;
      cmd_load <= 1'b0;
      cmd_path <= 1'b0;
      cmd_index <= '0;
      cmd_freq <= '0;
      trig_pin <= 1'b0;
      capture_en <= 1'b0;
      sweep_busy <= 1'b0;
      sweep_end <= 1'b0;
      err_code <= EGS_ERR_NONE;
      err_pulse <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      idx <= next_idx;
      cnt <= next_cnt;
      loaded <= next_loaded;
      ttl_mode <= next_ttl_mode;
      cmd_valid <= next_cmd_valid;
      cmd_load <= next_cmd_load;
      cmd_path <= next_cmd_path;
      cmd_index <= next_cmd_index;
      cmd_freq <= next_cmd_freq;
      trig_pin <= next_trig;
      capture_en <= next_capture_en;
      sweep_busy <= next_busy;
      sweep_end <= next_end;
      err_code <= next_err;
      err_pulse <= next_err_pulse;
    end
  end

  // point_index mirrors idx from a flop
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      point_index <= '0;
    end else if (ce) begin
      point_index <= next_idx;
    end
  end
endmodule // egs_step_seq

// ### design/egs_regs.svh
`ifndef EGS_REGS_SVH
`define EGS_REGS_SVH
// ==========================================
// path selection codes
`define EGS_PATH_LAN 1'b0
`define EGS_PATH_GPIB 1'b1
// ==========================================
// timing
`define EGS_CLK_MHZ 40
`define EGS_TRIG_PULSE_NS 100
`define EGS_TRIG_PULSE_CYC ((`EGS_TRIG_PULSE_NS * `EGS_CLK_MHZ + 999) / 1000)
`define EGS_ACK_TIMEOUT_US 100
`define EGS_ACK_TIMEOUT_CYC (`EGS_ACK_TIMEOUT_US * `EGS_CLK_MHZ)
`define EGS_PTS_DEPTH 1024
`define EGS_FREQ_W 32
`endif

// ### design/egs_pkg.sv
package egs_pkg;
  typedef enum logic [3:0] {
    EGS_IDLE,
    EGS_CHECK,
    EGS_LOAD_RD,
    EGS_LOAD_SEND,
    EGS_LOAD_WAIT,
    EGS_SET_RD,
    EGS_SET_SEND,
    EGS_SET_WAIT,
    EGS_TRIG,
    EGS_SETTLE,
    EGS_CAPTURE,
    EGS_DONE
  } egs_state_t;
  typedef enum logic [1:0] {
    EGS_ERR_NONE,
    EGS_ERR_GPIB,
    EGS_ERR_TCPIP
  } egs_err_t;
endpackage

// ### design/egs_point_mem.sv
`timescale 1ns/1ps
module egs_point_mem #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 1024,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic clk,
  input wire logic ce,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [DEPTH];
  // read data registered; one cycle latency
  always_ff @(posedge clk) begin
    if (ce) begin
      if (wr_en) begin
        mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
    end
  end
endmodule // egs_point_mem

// ### test/egs_step_seq_monitor.sv
`timescale 1ns/1ps
module egs_step_seq_monitor #(
  parameter int AW = 10
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic sweep_start,
  input wire logic cmd_ready,
  input wire logic capture_done,
  input wire logic cmd_valid,
  input wire logic cmd_load,
  input wire logic cmd_path,
  input wire logic [AW-1:0] cmd_index,
  input wire logic [AW-1:0] point_index,
  input wire logic trig_pin,
  input wire logic capture_en,
  input wire logic sweep_busy,
  input wire logic sweep_end,
  input wire egs_pkg::egs_err_t err_code,
  input wire logic err_pulse
);
  import egs_pkg::*;
  // ==========
  // properties
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence pulse4_s;
    trig_pin [*4] ##1 !trig_pin;
  endsequence
  sequence quiet_s;
    !trig_pin && !cmd_valid && !capture_en;
  endsequence
  trig_width_a: assert property ($rose(trig_pin) |-> pulse4_s)
    else $error("step width");
  cmd_hold_a: assert property (cmd_valid && !cmd_ready && ce |=>
    cmd_valid && $stable(cmd_index) && $stable(cmd_load)) else $error("cmd dropped");
  err_single_a: assert property (err_pulse |=> !err_pulse) else $error("err width");
  err_code_a: assert property (err_pulse |=> err_code != EGS_ERR_NONE)
    else $error("no err code");
  end_quiet_a: assert property (sweep_end |-> !sweep_busy ##1 quiet_s [*2])
    else $error("active after end");
  cap_release_a: assert property (capture_en && capture_done && ce |=> !capture_en)
    else $error("capture held");
  start_busy_a: assert property (sweep_start && ce && !sweep_busy && !sweep_end
    |=> sweep_busy) else $error("start lost");
  lan_load_a: assert property (cmd_valid && !cmd_path |-> !cmd_load)
    else $error("list load on lan");
  cap_notrig_a: assert property (capture_en |-> !trig_pin) else $error("capture in step");
  index_match_a: assert property (cmd_valid |-> point_index == cmd_index)
    else $error("index skew");
endmodule // egs_step_seq_monitor
bind egs_step_seq egs_step_seq_monitor #(.AW(AW)) egs_step_seq_monitor_inst (.*);

// ### test/egs_gen_model.sv
`timescale 1ns/1ps
module egs_gen_model (
  input wire logic clk,
  input wire logic slow,
  input wire logic cmd_valid,
  input wire logic cmd_load,
  input wire logic cmd_path,
  input wire logic [9:0] cmd_index,
  input wire logic [31:0] cmd_freq,
  input wire logic trig_pin,
  output logic cmd_ready,
  output logic cmd_done,
  output logic settle_pin
);
  logic [31:0] got [0:15];
  logic last_path = 0;
  logic tl = 0;
  int n_load = 0, n_prog = 0, n_trig = 0, pend = 0, sw = 0;
  initial {cmd_ready, cmd_done, settle_pin} = 3'h0;
  always @(posedge clk) begin
    // slow mode stalls the channel every other cycle
    cmd_ready <= !slow || !cmd_ready;
    cmd_done <= pend == 1;
    pend <= pend > 0 ? pend - 1 : 0;
    if (cmd_valid && cmd_ready) begin
      got[cmd_index[3:0]] <= cmd_freq;
      last_path <= cmd_path;
      pend <= slow ? 9 : 2;
      if (cmd_load) n_load++;
      else n_prog++;
    end
    tl <= trig_pin;
    sw <= sw > 0 ? sw - 1 : 0;
    if (tl && !trig_pin) begin
      n_trig++;
      sw <= slow ? 20 : 6;
    end
    settle_pin <= sw inside {[1:4]};
  end
endmodule // egs_gen_model

// ### test/test_ext_generator_step_handshake.sv
`timescale 1ns/1ps
module test_ext_generator_step_handshake;
  import egs_pkg::*;
  logic clk = 0, sys_rst = 1, ce = 1, gen_selected = 1, path_sel = 0, gen_ttl_capable = 0;
  logic addr_valid = 1, gen_ready = 1, pt_wr_en = 0, sweep_start = 0, list_invalidate = 0;
  logic capture_done = 0, slow = 0;
  logic [9:0] pt_wr_addr = 0, last_index = 10'h3, cmd_index, point_index;
  logic [31:0] pt_wr_data = 0, cmd_freq;
  logic [31:0] exp_f [0:3];
  logic cmd_ready, cmd_done, settle_pin, cmd_valid, cmd_load, cmd_path, trig_pin;
  logic capture_en, sweep_busy, sweep_end, err_pulse;
  egs_err_t err_code;
  int n_mismatch = 0, check_count = 0, seed = 23482, n_cap = 0, i, k;
  egs_step_seq #(.ACK_TIMEOUT(50)) egs_step_seq_inst (.*);
  egs_gen_model egs_gen_model_inst (.*);
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    capture_done <= capture_en && !capture_done && $random(seed) % 3 == 0;
    if (capture_en && capture_done) n_cap++;
  end
  task end_of_test;
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task chk(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask
  // ==========
  // one sweep, counted at the generator
  task run(input logic ttl, p, input int el, ep, et, input egs_err_t ee);
    int l0, p0, t0, c0, j;
    @(negedge clk);
    l0 = egs_gen_model_inst.n_load;
    p0 = egs_gen_model_inst.n_prog;
    t0 = egs_gen_model_inst.n_trig;
    c0 = n_cap;
    @(posedge clk);
    sweep_start <= 1;
    gen_ttl_capable <= ttl;
    path_sel <= p;
    @(posedge clk);
    sweep_start <= 0;
    for (j = 0; j < 3000 && !sweep_end && !err_pulse; j++) @(posedge clk);
    if (j == 3000) begin
      chk(0, "sweep hang");
      end_of_test;
    end
    repeat (8) @(negedge clk);
    chk(err_code === ee, "error code");
    chk(egs_gen_model_inst.n_load - l0 == el, "list loads");
    chk(egs_gen_model_inst.n_prog - p0 == ep, "programmed points");
    chk(egs_gen_model_inst.n_trig - t0 == et, "step requests");
    chk(n_cap - c0 == (ee == EGS_ERR_NONE ? 4 : 0), "captures");
    chk(point_index === (ee == EGS_ERR_NONE ? last_index : 10'h0), "last point");
    if (el + ep > 0) begin
      chk(egs_gen_model_inst.last_path === p, "path");
      for (j = 0; j < 4; j++) chk(egs_gen_model_inst.got[j] === exp_f[j], "frequency");
    end
    // hand back on a rising edge so the next stimulus lands there
    @(posedge clk);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    sys_rst <= 0;
    for (i = 0; i < 4; i++) begin
      @(posedge clk);
      k = $random(seed);
      exp_f[i] = 32'(k);
      pt_wr_en <= 1;
      pt_wr_addr <= 10'(i);
      pt_wr_data <= 32'(k);
    end
    @(posedge clk);
    pt_wr_en <= 0;
    run(0, 1, 0, 4, 0, EGS_ERR_NONE);
    slow <= 1;
    run(0, 0, 0, 4, 0, EGS_ERR_NONE);
    run(1, 1, 4, 0, 4, EGS_ERR_NONE);
    slow <= 0;
    run(1, 1, 0, 0, 4, EGS_ERR_NONE);
    run(1, 0, 0, 4, 0, EGS_ERR_NONE);
    @(posedge clk);
    list_invalidate <= 1;
    @(posedge clk);
    list_invalidate <= 0;
    run(1, 1, 4, 0, 4, EGS_ERR_NONE);
    // frozen: a start strobe while ce is low must be lost
    ce <= 0;
    sweep_start <= 1;
    @(posedge clk);
    sweep_start <= 0;
    repeat (3) @(posedge clk);
    ce <= 1;
    @(posedge clk);
    chk(sweep_busy === 1'b0, "start taken while frozen");
    for (i = 0; i < 3; i++) begin
      gen_selected <= i != 0;
      addr_valid <= i != 1;
      gen_ready <= i != 2;
      run(1, i[0], 0, 0, 0, i[0] ? EGS_ERR_GPIB : EGS_ERR_TCPIP);
    end
    end_of_test;
  end
endmodule // test_ext_generator_step_handshake
